// [hdl/mhi_host_if.sv]
// Behaviour
// - strap high parallel bus, low serial input
// - serial mode never drives read data
// - style strap picks 6800 or 8080 strobes
// - select line picks memory or command/status
// - write with select low is command
// - serial data D7, clock D6, when selected
// - serial bits MSB first on rising clock
// - eighth rising edge delivers the byte
// - select low marks serial byte as command
// - select sampled at every eighth edge
// - deselect clears shift register and counter
// - deselect floats bus, ignores all strobes
// - serial mode keeps D0 to D5 floating
// - 8080 write taken at write strobe rise
// - 6800 direction high reads, low writes
// - busy on D7; busy blocks writes and read advance only
`timescale 1ns/1ps
module mhi_host_if (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // straps
  input wire logic parSerStrap,
  input wire logic busStyleStrap,
  // host pins
  input wire logic chipSelectLowActiveN,
  input wire logic chipSelectHighActive,
  input wire logic dataCommandSelect,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire logic [mhi_pkg::BUS_W-1:0] dataIn,
  output logic [mhi_pkg::BUS_W-1:0] dataOut,
  output logic [mhi_pkg::BUS_W-1:0] dataOeN,
  // core side
  input wire logic busyFlag,
  input wire logic [mhi_pkg::BUS_W-2:0] statusBits,
  input wire logic [mhi_pkg::BUS_W-1:0] rdHoldData,
  output logic hostWrStrobe,
  output logic hostWrIsData,
  output logic [mhi_pkg::BUS_W-1:0] hostWrByte,
  output logic hostRdAdvance
);
  import mhi_pkg::*;

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] prev_q;
  logic parMode, style6800, sel, selPrev, active;
  logic wrRise, rdRise, eFall, parWrite, parReadActive, parReadEnd;
  logic sclRise, serSel, serEdge, serLast;
  logic [BUS_W-1:0] serByte;
  logic [BUS_W-1:0] shift_q;
  logic [2:0] bitCnt_q;
  logic wrStrobe_q, wrIsData_q, rdAdvance_q;
  logic [BUS_W-1:0] wrByte_q, dOut_q, dOeN_q;

  assign pins = {parSerStrap, busStyleStrap, chipSelectLowActiveN,
                 chipSelectHighActive, dataCommandSelect, rdStrobeN,
                 wrStrobeN, dataIn};

  // two-stage synchroniser plus one history stage for edge finding
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync1_q <= PIN_RST;
      sync2_q <= PIN_RST;
      prev_q <= PIN_RST;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // mode and select decode; edges need select in both samples so the
  // reset history cannot fake a strobe edge
  assign parMode = sync2_q[PIN_PS];
  assign style6800 = sync2_q[PIN_STYLE];
  assign sel = !sync2_q[PIN_CSLN] && sync2_q[PIN_CSH];
  assign selPrev = !prev_q[PIN_CSLN] && prev_q[PIN_CSH];
  assign active = sel && selPrev;

  // strobe edges; in 6800 style the read strobe pin is the enable
  assign wrRise = !prev_q[PIN_WRN] && sync2_q[PIN_WRN];
  assign rdRise = !prev_q[PIN_RDN] && sync2_q[PIN_RDN];
  assign eFall = prev_q[PIN_RDN] && !sync2_q[PIN_RDN];

  // write taken at /WR rise or at enable fall with direction low
  assign parWrite = parMode && active &&
    (style6800 ? (eFall && !prev_q[PIN_WRN]) : wrRise);
  // read drive window: /RD low, or enable high with direction high
  assign parReadActive = parMode && sel &&
    (style6800 ? (sync2_q[PIN_RDN] && sync2_q[PIN_WRN])
               : !sync2_q[PIN_RDN]);
  assign parReadEnd = parMode && active &&
    (style6800 ? (eFall && prev_q[PIN_WRN]) : rdRise);

  // serial clock and data live on the top two data pins
  assign serSel = !parMode && sel;
  assign sclRise = !prev_q[SER_SCL] && sync2_q[SER_SCL];
  assign serEdge = serSel && selPrev && sclRise;
  assign serLast = serEdge && (bitCnt_q == SER_LAST);
  assign serByte = {shift_q[BUS_W-2:0], sync2_q[SER_SI]};

  // shift register and bit counter, cleared whenever deselected
  always_ff @(posedge sys_clk) begin
    if (!nrst || !serSel) begin
      shift_q <= BYTE_ZERO;
      bitCnt_q <= CNT_ZERO;
    end else if (serEdge) begin
      shift_q <= serByte;
      bitCnt_q <= bitCnt_q + CNT_ONE; // wraps after the eighth bit
    end
  end

  // byte hand-off to the core; a busy core drops writes, which is why
  // the host must poll status or keep the cycle time
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wrStrobe_q <= 1'b0;
      wrIsData_q <= 1'b0;
      wrByte_q <= BYTE_ZERO;
    end else begin
      wrStrobe_q <= (parWrite || serLast) && !busyFlag;
      if (parWrite) begin
        wrIsData_q <= prev_q[PIN_DCS];
        wrByte_q <= prev_q[PIN_DATA_LSB +: BUS_W];
      end else if (serLast) begin
        wrIsData_q <= sync2_q[PIN_DCS];
        wrByte_q <= serByte;
      end
    end
  end

  // end of a display read steps the core's read holder; the first
  // read after an address set returns stale holder data by design
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdAdvance_q <= 1'b0;
    end else begin
      rdAdvance_q <= parReadEnd && prev_q[PIN_DCS]
        && !busyFlag;
    end
  end

  // read data drive; serial mode and deselect leave all lines floating
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dOut_q <= BYTE_ZERO;
      dOeN_q <= OE_OFF;
    end else if (parReadActive) begin
      dOeN_q <= OE_ON;
      if (sync2_q[PIN_DCS]) begin
        dOut_q <= rdHoldData;
      end else begin
        dOut_q <= {busyFlag, statusBits};
      end
    end else begin
      dOeN_q <= OE_OFF;
      dOut_q <= BYTE_ZERO;
    end
  end

  assign dataOut = dOut_q;
  assign dataOeN = dOeN_q;
  assign hostWrStrobe = wrStrobe_q;
  assign hostWrIsData = wrIsData_q;
  assign hostWrByte = wrByte_q;
  assign hostRdAdvance = rdAdvance_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_serLast;
    serLast && !busyFlag;
  endsequence

  property p_serialNoDrive;
    !parMode |=> dataOeN == OE_OFF;
  endproperty
  a_serialNoDrive: assert property (p_serialNoDrive)
    else $error("data bus driven in serial mode");

  property p_deselFloat;
    !sel |=> dataOeN == OE_OFF && !hostRdAdvance;
  endproperty
  a_deselFloat: assert property (p_deselFloat)
    else $error("data bus driven while deselected");

  property p_deselClear;
    !serSel |=> bitCnt_q == CNT_ZERO && shift_q == BYTE_ZERO;
  endproperty
  a_deselClear: assert property (p_deselClear)
    else $error("serial state kept while deselected");

  property p_serByte;
    logic [BUS_W-1:0] b;
    (s_serLast, b = serByte) |=> hostWrStrobe && hostWrByte == b;
  endproperty
  a_serByte: assert property (p_serByte)
    else $error("serial byte not delivered on eighth edge");

  property p_serKind;
    s_serLast |=> hostWrIsData == $past(sync2_q[PIN_DCS]);
  endproperty
  a_serKind: assert property (p_serKind)
    else $error("serial byte kind not taken from select line");

  property p_wr8080;
    parMode && !style6800 && active && wrRise && !busyFlag |=>
      hostWrStrobe && hostWrByte == $past(prev_q[BUS_W-1:0]);
  endproperty
  a_wr8080: assert property (p_wr8080)
    else $error("8080 write not taken at strobe rise");

  property p_wr6800;
    parMode && style6800 && active && eFall && !prev_q[PIN_WRN]
      && !busyFlag |=> hostWrStrobe ##1 !hostWrStrobe;
  endproperty
  a_wr6800: assert property (p_wr6800)
    else $error("6800 write not a single pulse at enable fall");

  property p_busyBlocks;
    busyFlag |=> !hostWrStrobe && !hostRdAdvance;
  endproperty
  a_busyBlocks: assert property (p_busyBlocks)
    else $error("operation accepted while busy");

  property p_statusBusy;
    parReadActive && !sync2_q[PIN_DCS] |=>
      dataOeN == OE_ON && dataOut[BUSY_BIT] == $past(busyFlag);
  endproperty
  a_statusBusy: assert property (p_statusBusy)
    else $error("busy not shown on status read");

endmodule : mhi_host_if

// [hdl/mhi_pkg.sv]
package mhi_pkg;
  // widths of the host data bus and of the sampled pin vector
  localparam int BUS_W = 8;
  localparam int PIN_W = 15;
  // positions inside the sampled pin vector
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_WRN = 8;
  localparam int PIN_RDN = 9;
  localparam int PIN_DCS = 10;
  localparam int PIN_CSH = 11;
  localparam int PIN_CSLN = 12;
  localparam int PIN_STYLE = 13;
  localparam int PIN_PS = 14;
  // serial lines ride on data bits, busy sits on the top data bit
  localparam int SER_SI = 7;
  localparam int SER_SCL = 6;
  localparam int BUSY_BIT = 7;
  // reset value: strobes idle high, chip deselected
  localparam logic [PIN_W-1:0] PIN_RST = 15'h1300;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam logic [BUS_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BUS_W-1:0] OE_OFF = 8'hFF;
  localparam logic [BUS_W-1:0] OE_ON = 8'h00;
endpackage : mhi_pkg

// [dv/mhi_host_model.sv]
`timescale 1ns/1ps
module mhi_host_model (
  // clock and bus as the host sees it
  input wire logic sys_clk,
  input wire logic [7:0] dIn,
  // host pins
  output logic csN,
  output logic csH,
  output logic dcSel,
  output logic rdN,
  output logic wrN,
  output logic [7:0] dOut,
  output logic drive
);
  import mhi_pkg::*;
  // start deselected with strobes idle
  initial {csN, csH, dcSel, rdN, wrN, drive, dOut} = 14'h2600;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // selects move on an edge, then settle past the input synchroniser
  task automatic sel(input logic lo, input logic hi);
    @(posedge sys_clk);
    csN <= lo;
    csH <= hi;
    tick(4);
  endtask : sel
  // park the strobes at the idle level of a bus style, while deselected
  task automatic park(input logic st);
    @(posedge sys_clk);
    {rdN, wrN} <= {!st, 1'b1};
    tick(4);
  endtask : park
  // phases of 4 or 8 clocks stay above the 3-clock minimum
  task automatic acc(input logic st, rd, dc, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge sys_clk);
    {dcSel, dOut, drive} <= {dc, d, !rd};
    if (st) {rdN, wrN} <= {1'b0, rd};
    tick(4);
    if (st) rdN <= 1'b1;
    else if (rd) rdN <= 1'b0;
    else wrN <= 1'b0;
    tick(8);
    q = dIn;
    rdN <= !st;
    tick(4);
    {drive, wrN} <= 2'b01;
  endtask : acc
  // clock 9 low then 11 high; strobe pins are left tied meanwhile
  task automatic ser(input logic dc, input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge sys_clk);
      {dcSel, drive, dOut} <= {dc, 1'b1, b[i], 7'h00};
      tick(9);
      dOut[6] <= 1'b1;
      tick(10);
    end
  endtask : ser
endmodule : mhi_host_model

// [dv/test_mpu_host_interface.sv]
`timescale 1ns/1ps
module test_mpu_host_interface;
  import mhi_pkg::*;
  logic sys_clk, nrst, parSerStrap, busStyleStrap, busyFlag;
  logic csN, csH, dcSel, rdN, wrN, drive, hostWrStrobe, hostWrIsData, adv;
  logic [6:0] statusBits;
  logic [7:0] rdHoldData, dataIn, dataOut, dataOeN, hostWrByte;
  logic [7:0] hD, noise, q, b;
  logic [8:0] seenWr;
  logic [8:0] expQ[$];
  int err_count, total_checks, advCnt, drv, drv0;
  // a released bus shows a pattern that flips every clock
  assign dataIn = drive ? hD : (dataOeN === OE_ON ? dataOut : noise);
  assign seenWr = {hostWrIsData, hostWrByte};
  mhi_host_model u_host (.sys_clk(sys_clk), .dIn(dataIn), .csN(csN),
    .csH(csH), .dcSel(dcSel), .rdN(rdN), .wrN(wrN), .dOut(hD),
    .drive(drive));
  mhi_host_if u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .parSerStrap(parSerStrap), .busStyleStrap(busStyleStrap),
    .chipSelectLowActiveN(csN), .chipSelectHighActive(csH),
    .dataCommandSelect(dcSel), .rdStrobeN(rdN), .wrStrobeN(wrN),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
    .busyFlag(busyFlag), .statusBits(statusBits), .rdHoldData(rdHoldData),
    .hostWrStrobe(hostWrStrobe), .hostWrIsData(hostWrIsData),
    .hostWrByte(hostWrByte), .hostRdAdvance(adv));
  task automatic check(input string nm, input logic [8:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic results();
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // each write strobe takes the oldest expected byte off the queue
  always @(posedge sys_clk) begin
    noise <= ~noise;
    if (adv === 1'b1) advCnt <= advCnt + 1;
    if (dataOeN !== OE_OFF) drv <= drv + 1;
    if (hostWrStrobe === 1'b1) begin
      if (expQ.size() == 0) check("extra write", 9'h000, 9'h100);
      else check("write", seenWr, expQ.pop_front());
    end
  end
  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    results();
  end
  initial begin
    void'($urandom(2900));
    {nrst, busyFlag, busStyleStrap, statusBits, rdHoldData} = '0;
    parSerStrap = 1'b1;
    noise = 8'h5A;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    u_host.sel(1'b0, 1'b1);
    for (int s = 0; s < 2; s++) begin
      // change style only while deselected with the strobes parked, so an
      // old idle level is never taken as an access in the new style
      u_host.sel(1'b1, 1'b1);
      busStyleStrap <= s[0];
      u_host.park(s[0]);
      u_host.sel(1'b0, 1'b1);
      for (int k = 0; k < 4; k++) begin
        b = 8'($urandom);
        expQ.push_back({k[0], b});
        u_host.acc(s[0], 1'b0, k[0], b, q);
      end
      // the last write is seen 3 clocks after its strobe ends; busy waits
      u_host.tick(4);
      busyFlag <= 1'b1;
      statusBits <= 7'($urandom);
      u_host.acc(s[0], 1'b1, 1'b0, 8'h00, q);
      check("status", {1'b0, q}, {2'b01, statusBits});
      u_host.acc(s[0], 1'b0, 1'b1, 8'hA5, q);
      u_host.tick(4); // the refused write must still meet busy high
      busyFlag <= 1'b0;
      rdHoldData <= 8'($urandom);
      u_host.acc(s[0], 1'b1, 1'b1, 8'h00, q);
      u_host.acc(s[0], 1'b1, 1'b1, 8'h00, q);
      check("read", {1'b0, q}, {1'b0, rdHoldData});
    end
    // from here on the bus must never be driven
    u_host.tick(6);
    drv0 = drv;
    for (int c = 0; c < 3; c++) begin
      u_host.sel(c[0] | c[1], c[1]);
      u_host.acc(1'b1, 1'b0, 1'b0, 8'h3C, q);
      u_host.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
    end
    // busy keeps garbage from the released bus from landing; the strobe
    // pins stay tied meanwhile, as serial mode asks of the host
    parSerStrap <= 1'b0;
    busyFlag <= 1'b1;
    u_host.sel(1'b0, 1'b1);
    u_host.tick(16);
    u_host.ser(1'b1, 8'hFF, 3);
    u_host.sel(1'b1, 1'b1);
    busyFlag <= 1'b0;
    u_host.sel(1'b0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      expQ.push_back({k[0], b});
      u_host.ser(k[0], b, 8);
    end
    u_host.tick(10);
    check("pending", 9'(expQ.size()), 9'h000);
    check("advance", 9'(advCnt), 9'h004);
    check("drive", 9'(drv - drv0), 9'h000);
    results();
  end
endmodule : test_mpu_host_interface
